/* File: bench/chas_line_model.sv */
module chas_line_model (
  input  wire logic       core_clk,
  input  wire logic       pulseOn,
  input  wire logic       dropRec,
  input  wire logic [3:0] fullRate,
  output logic            bitEnable            = 1'b0,
  output logic            linePulse            = 1'b0,
  output logic            recClkTick           = 1'b0,
  output logic            e3_reference_clock   = 1'b0,
  output logic            ds3_reference_clock  = 1'b0,
  output logic            sts1_reference_clock = 1'b0,
  output logic            synthClkTick         = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Line bit timing and clock strobes
  // ************************************************************
  logic [7:0] phase = 8'h00;

  // One line bit every four core cycles; pulses only when asked for.
  always_ff @(posedge core_clk) begin
    phase     <= phase + 8'h01;
    bitEnable <= (phase[1:0] == 2'b11);
    linePulse <= pulseOn & (phase[1:0] == 2'b11);
  end

  // Dropping one tick in 32 pulls the recovered rate about 3 percent off.
  // A reference not at full rate runs at half rate, so a wrong choice of
  // reference shows up as a large deviation.
  always_ff @(posedge core_clk) begin
    recClkTick           <= !(dropRec && phase[4:0] == 5'h00);
    e3_reference_clock   <= fullRate[0] | phase[0];
    ds3_reference_clock  <= fullRate[1] | phase[0];
    sts1_reference_clock <= fullRate[2] | phase[0];
    synthClkTick         <= fullRate[3] | phase[0];
  end
endmodule

/* File: bench/chas_status_bank_tb.sv */
module chas_status_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Signals
  // ************************************************************
  logic        core_clk        = 1'b0;
  logic        reset_n         = 1'b0;
  logic        psel            = 1'b0;
  logic        penable         = 1'b0;
  logic        pwrite          = 1'b0;
  logic [7:0]  paddr           = 8'h00;
  logic [31:0] pwdata          = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        ampBelowDeclare = 1'b0;
  logic        ampAboveClear   = 1'b1;
  logic [5:0]  fifoFill        = 6'h08;
  logic        pulseOn         = 1'b1;
  logic        dropRec         = 1'b0;
  logic [3:0]  fullRate        = 4'hf;
  logic        bitEnable;
  logic        linePulse;
  logic        recClkTick;
  logic        e3Ref;
  logic        ds3Ref;
  logic        sts1Ref;
  logic        synthTick;
  logic [31:0] rdData;
  logic        rdErr;
  int          n_errors        = 0;
  int          total_checks    = 0;

  localparam logic [7:0] F_CTRL [9] = '{8'h02, 8'h22, 8'h22, 8'h22, 8'h22,
                                        8'h32, 8'h32, 8'h32, 8'h32};
  localparam logic [5:0] F_FILL [9] = '{6'h01, 6'h02, 6'h03, 6'h0d, 6'h0e,
                                        6'h02, 6'h1d, 6'h1e, 6'h03};
  localparam logic       F_EXP  [9] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1,
                                        1'b1, 1'b0, 1'b1, 1'b0};

  // ************************************************************
  // Instances
  // ************************************************************
  chas_status_bank chas_status_bank_inst (
    .core_clk(core_clk), .reset_n(reset_n), .cke(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .ampBelowDeclare(ampBelowDeclare),
    .ampAboveClear(ampAboveClear), .bitEnable(bitEnable),
    .linePulse(linePulse), .fifoFill(fifoFill), .recClkTick(recClkTick),
    .e3_reference_clock(e3Ref), .ds3_reference_clock(ds3Ref),
    .sts1_reference_clock(sts1Ref), .synthClkTick(synthTick));

  chas_line_model chas_line_model_inst (
    .core_clk(core_clk), .pulseOn(pulseOn), .dropRec(dropRec),
    .fullRate(fullRate), .bitEnable(bitEnable), .linePulse(linePulse),
    .recClkTick(recClkTick), .e3_reference_clock(e3Ref),
    .ds3_reference_clock(ds3Ref), .sts1_reference_clock(sts1Ref),
    .synthClkTick(synthTick));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // The answer is awaited under a bound so a stuck slave cannot hang us.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) n_errors++;
    rdData = prdata;
    rdErr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic checkVal(input string name, input logic [31:0] exp,
                          input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask

  task automatic expectReg(input string name, input logic [7:0] a,
                           input logic [31:0] exp, input logic expErr);
    apb(1'b0, a, 32'h0);
    checkVal(name, exp, rdData);
    checkVal({name, " slverr"}, {31'h0, expErr}, {31'h0, rdErr});
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic testReset();
    expectReg("status", chas_pkg::OFF_STATUS, 32'h0, 1'b0);
    expectReg("ctrl", chas_pkg::OFF_CTRL, 32'h02, 1'b0);
    expectReg("int en", chas_pkg::OFF_INT_EN, 32'h0, 1'b0);
    expectReg("unmapped", 8'h40, 32'h0, 1'b1);
    apb(1'b1, chas_pkg::OFF_STATUS, 32'hff);
    expectReg("status ro", chas_pkg::OFF_STATUS, 32'h0, 1'b0);
  endtask

  task automatic testAnalog();
    apb(1'b1, chas_pkg::OFF_INT_EN, 32'hf);
    ampBelowDeclare <= 1'b1;
    ampAboveClear   <= 1'b0;
    idle(8);
    expectReg("analog", chas_pkg::OFF_STATUS, 32'h12, 1'b0);
    checkVal("irq", 32'h1, {31'h0, irq});
    expectReg("int stat", chas_pkg::OFF_INT_STAT, 32'h9, 1'b0);
    ampBelowDeclare <= 1'b0;
    idle(8);
    expectReg("hyst", chas_pkg::OFF_STATUS, 32'h12, 1'b0);
    expectReg("reread", chas_pkg::OFF_STATUS, 32'h12, 1'b0);
    ampAboveClear <= 1'b1;
    idle(8);
    expectReg("cleared", chas_pkg::OFF_STATUS, 32'h0, 1'b0);
    apb(1'b1, chas_pkg::OFF_INT_CLR, 32'h9);
    idle(3);
    checkVal("irq clr", 32'h0, {31'h0, irq});
    apb(1'b1, chas_pkg::OFF_INT_EN, 32'h0);
    ampBelowDeclare <= 1'b1;
    ampAboveClear   <= 1'b0;
    idle(8);
    checkVal("irq masked", 32'h0, {31'h0, irq});
    expectReg("int stat m", chas_pkg::OFF_INT_STAT, 32'h9, 1'b0);
    apb(1'b1, chas_pkg::OFF_INT_EN, 32'h8);
    idle(3);
    checkVal("irq unmask", 32'h1, {31'h0, irq});
    ampBelowDeclare <= 1'b0;
    ampAboveClear   <= 1'b1;
    apb(1'b1, chas_pkg::OFF_INT_CLR, 32'hf);
    idle(8);
    checkVal("irq end", 32'h0, {31'h0, irq});
  endtask

  // Bits last four cycles, so 600 cycles stay short of the 160-bit run.
  task automatic testDigital();
    pulseOn <= 1'b0;
    idle(600);
    expectReg("dig early", chas_pkg::OFF_STATUS, 32'h0, 1'b0);
    idle(100);
    expectReg("dig loss", chas_pkg::OFF_STATUS, 32'h02, 1'b0);
    pulseOn <= 1'b1;
    idle(300);
    expectReg("dig clear", chas_pkg::OFF_STATUS, 32'h0, 1'b0);
  endtask

  task automatic testFifo();
    for (int k = 0; k < 9; k++) begin
      apb(1'b1, chas_pkg::OFF_CTRL, {24'h0, F_CTRL[k]});
      fifoFill <= F_FILL[k];
      idle(4);
      expectReg("fifo", chas_pkg::OFF_STATUS, {28'h0, F_EXP[k], 3'h0}, 1'b0);
    end
    apb(1'b1, chas_pkg::OFF_CTRL, 32'h02);
    fifoFill <= 6'h08;
  endtask

  task automatic testLock();
    idle(4100);
    expectReg("locked", chas_pkg::OFF_STATUS, 32'h0, 1'b0);
    dropRec <= 1'b1;
    idle(4100);
    expectReg("lock lost", chas_pkg::OFF_STATUS, 32'h04, 1'b0);
    dropRec  <= 1'b0;
    fullRate <= 4'h8;
    apb(1'b1, chas_pkg::OFF_CTRL, 32'h0a);
    idle(4100);
    expectReg("synth lock", chas_pkg::OFF_STATUS, 32'h0, 1'b0);
    apb(1'b1, chas_pkg::OFF_CTRL, 32'h02);
    idle(8200);
    expectReg("ref slow", chas_pkg::OFF_STATUS, 32'h04, 1'b0);
    fullRate <= 4'h4;
    apb(1'b1, chas_pkg::OFF_CTRL, 32'h04);
    idle(4100);
    expectReg("sts1 lock", chas_pkg::OFF_STATUS, 32'h0, 1'b0);
    fullRate        <= 4'h1;
    ampBelowDeclare <= 1'b1;
    ampAboveClear   <= 1'b0;
    apb(1'b1, chas_pkg::OFF_CTRL, 32'h01);
    idle(4100);
    expectReg("e3 lock", chas_pkg::OFF_STATUS, 32'h0, 1'b0);
    ampBelowDeclare <= 1'b0;
    ampAboveClear   <= 1'b1;
  endtask

  // ************************************************************
  // Clock, sequence and watchdog
  // ************************************************************
  initial begin
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    testReset();
    testAnalog();
    testDigital();
    testFifo();
    testLock();
    summarize();
  end

  initial begin
    repeat (60000) @(posedge core_clk);
    n_errors++;
    summarize();
  end
endmodule

/* File: common/chas_pkg.sv */
package chas_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFF_STATUS    = 8'h00;
  localparam logic [7:0]  OFF_CTRL      = 8'h04;
  localparam logic [7:0]  OFF_INT_STAT  = 8'h08;
  localparam logic [7:0]  OFF_INT_EN    = 8'h0c;
  localparam logic [7:0]  OFF_INT_CLR   = 8'h10;

  localparam int          BIT_ANALOG    = 4;
  localparam int          BIT_FIFO      = 3;
  localparam int          BIT_LOCK      = 2;
  localparam int          BIT_LOSS      = 1;
  localparam logic [7:0]  STATUS_RESET  = 8'h00;
  localparam logic [3:0]  INT_RESET     = 4'h0;

  // ************************************************************
  // Detector figures
  // ************************************************************
  localparam int          ZERO_RUN_BITS = 160;
  localparam int          DENSITY_WIN   = 32;
  localparam int          DENSITY_PCT   = 33;
  localparam int          DENSITY_MIN   =
    (DENSITY_WIN * DENSITY_PCT + 99) / 100;
  localparam int          LIMIT_MARGIN  = 2;
  localparam int          FIFO_SMALL    = 16;
  localparam int          FIFO_LARGE    = 32;
  localparam int          LOCK_WINDOW   = 2000;
  localparam int          LOCK_PPM      = 5000;
  localparam int          LOCK_TOL      =
    LOCK_WINDOW * LOCK_PPM / 1000000;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    RATE_E3   = 3'b001,
    RATE_DS3  = 3'b010,
    RATE_STS1 = 3'b100
  } chas_rate_type;

  typedef enum logic [1:0] {
    LOS_CLEAR    = 2'b01,
    LOS_DECLARED = 2'b10
  } chas_los_type;

  typedef struct packed {
    logic          attenEnable;
    logic          fifoLarge;
    logic          synthMode;
    chas_rate_type rate;
  } chas_ctrl_type;

  localparam chas_ctrl_type CTRL_RESET = '{1'b0, 1'b0, 1'b0, RATE_DS3};

  typedef struct packed {
    logic analogLoss;
    logic fifoAlarm;
    logic lockLost;
    logic channelLoss;
  } chas_alarm_type;

endpackage

/* File: rtl/chas_bit_sync.sv */
module chas_bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic             cke,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  // ************************************************************
  // Two-stage synchroniser
  // ************************************************************
  // The first stage feeds only the second one.
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      stage1  <= '0;
      syncOut <= '0;
    end else if (cke) begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule

/* File: rtl/chas_status_bank.sv */
// Local design decisions: register access over APB and the placing of the registers.
module chas_status_bank #(
  parameter int LOCK_WINDOW = chas_pkg::LOCK_WINDOW,
  parameter int FILL_W      = 6
) (
  input  wire logic                       core_clk,
  input  wire logic                       reset_n,
  input  wire logic                       cke,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [chas_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic                            irq,
  input  wire logic                       ampBelowDeclare,
  input  wire logic                       ampAboveClear,
  input  wire logic                       bitEnable,
  input  wire logic                       linePulse,
  input  wire logic [FILL_W-1:0]          fifoFill,
  input  wire logic                       recClkTick,
  input  wire logic                       e3_reference_clock,
  input  wire logic                       ds3_reference_clock,
  input  wire logic                       sts1_reference_clock,
  input  wire logic                       synthClkTick
);

  localparam int ZW = $clog2(chas_pkg::ZERO_RUN_BITS + 1);
  localparam int DW = $clog2(chas_pkg::DENSITY_WIN + 1);
  localparam int LW = $clog2(LOCK_WINDOW + chas_pkg::LOCK_TOL + 2);

  chas_pkg::chas_ctrl_type  ctrl;
  chas_pkg::chas_alarm_type alarm;
  logic                     analogLoss;
  logic                     fifoAlarm;
  logic                     lockLost;
  chas_pkg::chas_los_type   losState;
  logic [7:0]               statusReg;
  logic [3:0]               intStatus;
  logic [3:0]               intEnable;
  logic [3:0]               prevAlarm;
  logic [1:0]               ampSync;
  logic                     dsRate;
  logic                     digitalLoss;
  logic [ZW-1:0]            zeroRun;
  logic [DW-1:0]            winCount;
  logic [DW-1:0]            pulseCount;
  logic [LW-1:0]            refCount;
  logic [LW-1:0]            recCount;
  logic [LW-1:0]            next_recCount;
  logic                     refTick;
  logic                     windowEnd;
  logic [FILL_W:0]          fifoTop;
  logic                     access;
  logic                     wrStrobe;
  logic                     mapped;

  // ************************************************************
  // Pin synchronisation
  // ************************************************************
  chas_bit_sync #(
    .WIDTH (2)
  ) ampSyncCell (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .cke      (cke),
    .asyncIn  ({ampAboveClear, ampBelowDeclare}),
    .syncOut  (ampSync)
  );

  // The E3 path uses a different detector kept outside this bank.
  assign dsRate = (ctrl.rate == chas_pkg::RATE_DS3) ||
                  (ctrl.rate == chas_pkg::RATE_STS1);

  // ************************************************************
  // Analog loss detector
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      analogLoss <= 1'b0;
    end else if (cke) begin
      if (!dsRate) begin
        analogLoss <= 1'b0;
      end else if (ampSync[0]) begin
        analogLoss <= 1'b1;
      end else if (ampSync[1]) begin
        analogLoss <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Digital loss detector
  // ************************************************************
  // Density is judged only over whole windows, so clearing lags a
  // restored signal by up to two windows; this avoids early clears.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      zeroRun <= '0;
    end else if (cke && bitEnable) begin
      if (linePulse) begin
        zeroRun <= '0;
      end else if (zeroRun != ZW'(chas_pkg::ZERO_RUN_BITS)) begin
        zeroRun <= zeroRun + ZW'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      winCount   <= '0;
      pulseCount <= '0;
    end else if (cke && bitEnable) begin
      if (winCount == DW'(chas_pkg::DENSITY_WIN - 1)) begin
        winCount   <= '0;
        pulseCount <= '0;
      end else begin
        winCount   <= winCount + DW'(1);
        pulseCount <= pulseCount + DW'(linePulse);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      losState <= chas_pkg::LOS_CLEAR;
    end else if (cke) begin
      case (losState)
        chas_pkg::LOS_CLEAR: begin
          if (dsRate && bitEnable && !linePulse &&
              zeroRun == ZW'(chas_pkg::ZERO_RUN_BITS - 1)) begin
            losState <= chas_pkg::LOS_DECLARED;
          end
        end
        chas_pkg::LOS_DECLARED: begin
          if (!dsRate) begin
            losState <= chas_pkg::LOS_CLEAR;
          end else if (bitEnable &&
              winCount == DW'(chas_pkg::DENSITY_WIN - 1) &&
              pulseCount + DW'(linePulse) >=
              DW'(chas_pkg::DENSITY_MIN)) begin
            losState <= chas_pkg::LOS_CLEAR;
          end
        end
        default: losState <= chas_pkg::LOS_CLEAR;
      endcase
    end
  end

  assign digitalLoss = (losState == chas_pkg::LOS_DECLARED);

  // ************************************************************
  // Jitter attenuator FIFO limit alarm
  // ************************************************************
  assign fifoTop = ctrl.fifoLarge ? (FILL_W+1)'(chas_pkg::FIFO_LARGE)
                                  : (FILL_W+1)'(chas_pkg::FIFO_SMALL);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      fifoAlarm <= 1'b0;
    end else if (cke) begin
      fifoAlarm <= ctrl.attenEnable &&
        ({1'b0, fifoFill} <= (FILL_W+1)'(chas_pkg::LIMIT_MARGIN) ||
         {1'b0, fifoFill} + (FILL_W+1)'(chas_pkg::LIMIT_MARGIN) >=
         fifoTop);
    end
  end

  // ************************************************************
  // Loss of lock
  // ************************************************************
  // Ticks are one-cycle strobes from the rate prescalers.
  always_comb begin
    if (ctrl.synthMode) begin
      refTick = synthClkTick;
    end else begin
      case (ctrl.rate)
        chas_pkg::RATE_E3:   refTick = e3_reference_clock;
        chas_pkg::RATE_DS3:  refTick = ds3_reference_clock;
        chas_pkg::RATE_STS1: refTick = sts1_reference_clock;
        default:             refTick = 1'b0;
      endcase
    end
  end

  assign windowEnd     = refTick &&
                         refCount == LW'(LOCK_WINDOW - 1);
  assign next_recCount = (&recCount) ? recCount
                                     : recCount + LW'(recClkTick);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      refCount <= '0;
      recCount <= '0;
      lockLost <= 1'b0;
    end else if (cke) begin
      if (windowEnd) begin
        refCount <= '0;
        recCount <= '0;
        lockLost <=
          next_recCount >= LW'(LOCK_WINDOW + chas_pkg::LOCK_TOL) ||
          next_recCount <= LW'(LOCK_WINDOW - chas_pkg::LOCK_TOL);
      end else begin
        refCount <= refCount + LW'(refTick);
        recCount <= next_recCount;
      end
    end
  end

  // ************************************************************
  // Status register
  // ************************************************************
  // Each detector keeps its own flop; the struct gathers them and ORs analogLoss with digitalLoss for channelLoss.
  assign alarm = '{analogLoss, fifoAlarm, lockLost,
                   analogLoss || digitalLoss};

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      statusReg <= chas_pkg::STATUS_RESET;
    end else if (cke) begin
      statusReg                       <= chas_pkg::STATUS_RESET;
      statusReg[chas_pkg::BIT_ANALOG] <= alarm.analogLoss;
      statusReg[chas_pkg::BIT_FIFO]   <= alarm.fifoAlarm;
      statusReg[chas_pkg::BIT_LOCK]   <= alarm.lockLost;
      statusReg[chas_pkg::BIT_LOSS]   <= alarm.channelLoss;
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  // A new rise beats a clear written in the same cycle.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      prevAlarm <= chas_pkg::INT_RESET;
      intStatus <= chas_pkg::INT_RESET;
      irq       <= 1'b0;
    end else if (cke) begin
      prevAlarm <= alarm;
      intStatus <= (intStatus & ~((wrStrobe &&
                   paddr == chas_pkg::OFF_INT_CLR) ? pwdata[3:0]
                   : 4'h0)) | (alarm & ~prevAlarm);
      irq       <= |(intStatus & intEnable);
    end
  end

  // ************************************************************
  // APB slave
  // ************************************************************
  // One wait state per transfer so that read data come from a flop.
  assign access   = psel && penable;
  assign wrStrobe = access && pready && pwrite;
  assign mapped   = paddr == chas_pkg::OFF_STATUS   ||
                    paddr == chas_pkg::OFF_CTRL     ||
                    paddr == chas_pkg::OFF_INT_STAT ||
                    paddr == chas_pkg::OFF_INT_EN   ||
                    paddr == chas_pkg::OFF_INT_CLR;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (cke) begin
      pready  <= access && !pready;
      pslverr <= access && !pready && !mapped;
      prdata  <= 32'h0;
      if (access && !pready && !pwrite) begin
        case (paddr)
          chas_pkg::OFF_STATUS:   prdata <= {24'h0, statusReg};
          chas_pkg::OFF_CTRL:     prdata <= {26'h0, ctrl};
          chas_pkg::OFF_INT_STAT: prdata <= {28'h0, intStatus};
          chas_pkg::OFF_INT_EN:   prdata <= {28'h0, intEnable};
          default:                prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ctrl      <= chas_pkg::CTRL_RESET;
      intEnable <= chas_pkg::INT_RESET;
    end else if (cke && wrStrobe) begin
      if (paddr == chas_pkg::OFF_CTRL) begin
        ctrl.attenEnable <= pwdata[5];
        ctrl.fifoLarge   <= pwdata[4];
        ctrl.synthMode   <= pwdata[3];
        case (pwdata[2:0])
          3'h1:    ctrl.rate <= chas_pkg::RATE_E3;
          3'h4:    ctrl.rate <= chas_pkg::RATE_STS1;
          default: ctrl.rate <= chas_pkg::RATE_DS3;
        endcase
      end
      if (paddr == chas_pkg::OFF_INT_EN) begin
        intEnable <= pwdata[3:0];
      end
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_analog_declare: assert property (
    cke && dsRate && ampSync[0] |=> alarm.analogLoss)
    else $error("analog loss not declared");
  a_analog_hyst: assert property (
    cke && dsRate && alarm.analogLoss && !ampSync[1] |=>
    alarm.analogLoss)
    else $error("analog loss cleared below clearance level");
  a_loss_or: assert property (
    cke ##1 cke |-> statusReg[chas_pkg::BIT_LOSS] ==
    $past(alarm.analogLoss || digitalLoss))
    else $error("channel loss bit not the OR of detectors");
  a_fifo_low: assert property (
    cke && ctrl.attenEnable && fifoFill <= FILL_W'(2) |=>
    alarm.fifoAlarm ##1 !cke || statusReg[chas_pkg::BIT_FIFO])
    else $error("fifo limit alarm missed near underrun");
  a_fifo_mid: assert property (
    cke && fifoFill > FILL_W'(2) &&
    {1'b0, fifoFill} + (FILL_W+1)'(2) < fifoTop |=> !alarm.fifoAlarm)
    else $error("fifo limit alarm held inside margin");
  a_fifo_gate: assert property (
    cke && !ctrl.attenEnable |=> !alarm.fifoAlarm)
    else $error("fifo limit alarm with attenuator off");
  a_lock_window: assert property (
    cke && !windowEnd |=> $stable(alarm.lockLost))
    else $error("lock state moved outside window end");
  a_digital_decl: assert property (
    cke && dsRate && bitEnable && !linePulse &&
    zeroRun == ZW'(chas_pkg::ZERO_RUN_BITS - 1) |=> digitalLoss)
    else $error("digital loss not declared after zero run");
  a_ready_pulse: assert property (
    pready |=> !pready)
    else $error("pready held longer than one cycle");

  c_analog_loss: cover property (cke && $rose(alarm.analogLoss));
  c_digital_loss: cover property (cke && $rose(digitalLoss));
  c_lock_lost: cover property (cke && $rose(alarm.lockLost));
  c_irq: cover property ($rose(irq));

endmodule
